/* File: core/gcsc_consts.vh */
// constants for the pin function and clock synchronisation block
`ifndef GCSC_CONSTS_VH
`define GCSC_CONSTS_VH
`define GCSC_ADDR_PIN_CFG0 8'h00
`define GCSC_ADDR_PIN_CFG5 8'h05
`define GCSC_ADDR_POLARITY 8'h06
`define GCSC_ADDR_SYNC_MODE 8'h07
`define GCSC_ADDR_RAIL_CTRL 8'h08
`define GCSC_ADDR_OUT_VALUE 8'h09
`define GCSC_ADDR_PG_SS 8'h0a
`define GCSC_ADDR_CLK_STATUS 8'h0b
`define GCSC_ADDR_PIN_STATUS 8'h0c
`define GCSC_ADDR_TARGET_ADDR 8'h0d
`define GCSC_RST_PIN_CFG 16'h0000
`define GCSC_RST_POLARITY 6'h00
`define GCSC_RST_SYNC_MODE 16'h0050
`define GCSC_RST_RAIL_CTRL 5'h00
`define GCSC_RST_OUT_VALUE 6'h00
`define GCSC_RST_TARGET_ADDR 7'h00
`define GCSC_SYNC_EXT_EN 0
`define GCSC_SYNC_AUTOBACK 1
`define GCSC_SYNC_ROLE_LSB 2
`define GCSC_SYNC_ROLE_MSB 3
`define GCSC_SYNC_PCT_LSB 4
`define GCSC_SYNC_PCT_MSB 7
`define GCSC_SYNC_OSC_LSB 8
`define GCSC_SYNC_OSC_MSB 10
`define GCSC_ROLE_ALONE 2'h0
`define GCSC_ROLE_MASTER 2'h1
`define GCSC_ROLE_SLAVE 2'h2
`define GCSC_CFG_SEL_LSB 0
`define GCSC_CFG_SEL_MSB 4
`define GCSC_CFG_FUNC_LSB 8
`define GCSC_CFG_FUNC_MSB 10
`define GCSC_FUNC_INPUT 3'h0
`define GCSC_FUNC_OUTPUT 3'h1
`define GCSC_FUNC_CLK_IN 3'h2
`define GCSC_FUNC_CLK_OUT 3'h3
`define GCSC_FUNC_SYNC_OUT 3'h4
`define GCSC_FUNC_RAIL_EN 3'h5
`define GCSC_FUNC_PWR_GOOD 3'h6
`define GCSC_FUNC_EVENT 3'h7
`define GCSC_NUM_EVENTS 18
`define GCSC_INT_HALF_BASE 4'h4
`define GCSC_DET_WINDOW 64
`define GCSC_SYNC_DIV 8
`endif

/* File: core/gcsc_freq_det.v */
// frequency window detector: external edges counted over internal clock window
`timescale 1ns/1ps
`include "gcsc_consts.vh"
module gcsc_freq_det #(
	parameter WIN = `GCSC_DET_WINDOW,
	parameter CW = 8
) (
	input wire core_clk_i,
	input wire rst_b_i,
	input wire clear_i,
	input wire ref_rise_i,
	input wire ext_rise_i,
	input wire [3:0] pct_i,
	output reg lock_o,
	output reg win_done_o
);
	localparam [15:0] WIN16 = WIN;
	localparam [CW-1:0] LAST = WIN - 1;
	localparam [CW-1:0] SAT = {CW{1'b1}};

	reg [CW-1:0] ref_cnt;
	reg [CW-1:0] ext_cnt;
	wire [CW-1:0] ext_total;
	wire [CW-1:0] lim_lo;
	wire [CW-1:0] lim_hi;

	function [CW-1:0] win_bound;
		input [3:0] pct;
		input up;
		reg [15:0] dev;
		begin
			dev = (WIN16 * {12'h000, pct}) / 16'h0064;
			if (up)
				win_bound = WIN16[CW-1:0] + dev[CW-1:0];
			else
				win_bound = WIN16[CW-1:0] - dev[CW-1:0];
		end
	endfunction

	// saturate so a very fast pin cannot wrap back into the window
	assign ext_total = (ext_cnt == SAT) ? SAT : ext_cnt + {{(CW-1){1'b0}}, ext_rise_i};
	assign lim_lo = win_bound(pct_i, 1'b0);
	assign lim_hi = win_bound(pct_i, 1'b1);

	always @(posedge core_clk_i)
	begin
		if (!rst_b_i || clear_i)
		begin
			ref_cnt <= {CW{1'b0}};
			ext_cnt <= {CW{1'b0}};
			lock_o <= 1'b0;
			win_done_o <= 1'b0;
		end
		else
		begin
			win_done_o <= 1'b0;
			if (ref_rise_i && ref_cnt == LAST)
			begin
				ref_cnt <= {CW{1'b0}};
				ext_cnt <= {CW{1'b0}};
				win_done_o <= 1'b1;
				lock_o <= (ext_total >= lim_lo) && (ext_total <= lim_hi);
			end
			else
			begin
				if (ref_rise_i)
					ref_cnt <= ref_cnt + {{(CW-1){1'b0}}, 1'b1};
				ext_cnt <= ext_total;
			end
		end
	end
endmodule // gcsc_freq_det

/* File: core/gcsc_clk_mux.v */
// glitch-free switch between internal and external clock waveforms
`timescale 1ns/1ps
module gcsc_clk_mux (
	input wire core_clk_i,
	input wire rst_b_i,
	input wire int_lvl_i,
	input wire ext_lvl_i,
	input wire want_ext_i,
	output reg main_clk_o,
	output reg ext_active_o
);
	localparam ST_RUN = 1'b0;
	localparam ST_HOLD = 1'b1;

	reg state;
	reg int_d;
	reg ext_d;
	wire src_lvl;
	wire src_d;
	wire tgt_lvl;
	wire tgt_d;

	assign src_lvl = ext_active_o ? ext_lvl_i : int_lvl_i;
	assign src_d = ext_active_o ? ext_d : int_d;
	assign tgt_lvl = want_ext_i ? ext_lvl_i : int_lvl_i;
	assign tgt_d = want_ext_i ? ext_d : int_d;

	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			state <= ST_RUN;
			int_d <= 1'b0;
			ext_d <= 1'b0;
			main_clk_o <= 1'b0;
			ext_active_o <= 1'b0;
		end
		else
		begin
			int_d <= int_lvl_i;
			ext_d <= ext_lvl_i;
			case (state)
			ST_RUN:
			begin
				// leave only while the source is low so the last high phase is whole;
				// a dead source parked low must still let the switch-back happen
				if (want_ext_i != ext_active_o && !src_lvl)
				begin
					state <= ST_HOLD;
					main_clk_o <= 1'b0;
				end
				else
					main_clk_o <= src_lvl;
			end
			ST_HOLD:
			begin
				// park low until the new source starts a fresh high phase
				if (!tgt_d && tgt_lvl)
				begin
					ext_active_o <= want_ext_i;
					state <= ST_RUN;
					main_clk_o <= 1'b1;
				end
				else
					main_clk_o <= 1'b0;
			end
			default:
			begin
				state <= ST_RUN;
				main_clk_o <= 1'b0;
			end
			endcase
		end
	end
endmodule // gcsc_clk_mux

/* File: core/gcsc_top.v */
// pin function logic, polarity, rail control and clock synchronisation top
//
// Contract
// - start on internal oscillator after power-up
// - switch to external clock inside window
// - no clock in window: stay internal
// - auto switch-back to internal on failure
// - software selects master or slave role
// - master drives clock and sync outputs
// - slave internal until loaded, then master clock
// - pins may act as clock inputs
// - pin config from OTP or bus
// - all configuration and status readable back
// - polarity bits invert pins zero to five
// - serial mode ignores upper two polarity writes
// - pin controls buck, standby or mix
// - rail-control pin enables and disables rails
// - host enables rails by register too
// - power-good pin only when assigned rails good
// - power-good state readable in status register
// - pin signals one selected fault event
// - 7-bit bus address from nonvolatile memory
`timescale 1ns/1ps
`include "gcsc_consts.vh"
module gcsc_top #(
	parameter NPIN = 6,
	parameter NRAIL = 5,
	parameter DET_WINDOW = `GCSC_DET_WINDOW,
	parameter SYNC_DIV = `GCSC_SYNC_DIV
) (
	input wire core_clk_i,
	input wire rst_b_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	output reg [15:0] reg_rdata_o,
	output reg reg_rvalid_o,
	input wire i2c_mode_i,
	input wire otp_load_i,
	input wire [95:0] otp_pin_cfg_i,
	input wire [5:0] otp_pol_i,
	input wire [15:0] otp_sync_i,
	input wire [6:0] otp_taddr_i,
	input wire [5:0] gpio_in_i,
	output reg [5:0] gpio_out_o,
	output reg [5:0] gpio_oe_o,
	input wire [4:0] rail_pg_i,
	input wire [4:0] rail_ss_done_i,
	input wire [17:0] event_i,
	output reg [4:0] rail_en_o,
	output wire main_clk_o,
	output wire ext_clk_active_o,
	output reg cfg_loaded_o,
	output reg [6:0] target_addr_o
);
	reg [15:0] pin_cfg [0:5];
	reg [5:0] pol;
	reg [15:0] sync_cfg;
	reg [4:0] host_rail;
	reg [5:0] out_value;
	reg [3:0] int_cnt;
	reg int_lvl;
	reg ext_d;
	reg ext_latch;
	reg main_d;
	reg [7:0] sync_cnt;
	reg sync_lvl;
	reg [2:0] clk_idx;
	reg clk_found;
	reg [5:0] next_out;
	reg [5:0] next_oe;
	reg [4:0] pin_rail_req;
	reg [15:0] next_rdata;
	integer i;

	wire [5:0] eff_in;
	wire [1:0] role;
	wire ext_mode;
	wire mst_on;
	wire [3:0] half;
	wire int_rise;
	wire ext_lvl;
	wire ext_rise;
	wire lock;
	wire win_done;
	wire main_rise;
	wire [7:0] sync_last;

	// decoded function and selector of one pin configuration word
	function [2:0] cfg_func;
		input [15:0] cfg;
		begin
			cfg_func = cfg[`GCSC_CFG_FUNC_MSB:`GCSC_CFG_FUNC_LSB];
		end
	endfunction

	function [4:0] cfg_sel;
		input [15:0] cfg;
		begin
			cfg_sel = cfg[`GCSC_CFG_SEL_MSB:`GCSC_CFG_SEL_LSB];
		end
	endfunction

	assign eff_in = gpio_in_i ^ pol;
	assign role = sync_cfg[`GCSC_SYNC_ROLE_MSB:`GCSC_SYNC_ROLE_LSB];
	assign ext_mode = (role == `GCSC_ROLE_SLAVE) || sync_cfg[`GCSC_SYNC_EXT_EN];
	assign mst_on = cfg_loaded_o && (role == `GCSC_ROLE_MASTER);
	assign half = `GCSC_INT_HALF_BASE + {1'b0, sync_cfg[`GCSC_SYNC_OSC_MSB:`GCSC_SYNC_OSC_LSB]};
	assign int_rise = (int_cnt == half - 4'h1) && !int_lvl;
	assign ext_lvl = clk_found ? eff_in[clk_idx] : 1'b0;
	assign ext_rise = ext_lvl && !ext_d;
	assign main_rise = main_clk_o && !main_d;
	assign sync_last = SYNC_DIV - 1;

	// register writes; an OTP load at the same edge takes precedence
	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			for (i = 0; i < NPIN; i = i + 1)
				pin_cfg[i] <= `GCSC_RST_PIN_CFG;
			pol <= `GCSC_RST_POLARITY;
			sync_cfg <= `GCSC_RST_SYNC_MODE;
			host_rail <= `GCSC_RST_RAIL_CTRL;
			out_value <= `GCSC_RST_OUT_VALUE;
			target_addr_o <= `GCSC_RST_TARGET_ADDR;
			cfg_loaded_o <= 1'b0;
		end
		else if (otp_load_i)
		begin
			for (i = 0; i < NPIN; i = i + 1)
				pin_cfg[i] <= otp_pin_cfg_i[i*16 +: 16];
			pol <= otp_pol_i;
			sync_cfg <= otp_sync_i;
			target_addr_o <= otp_taddr_i;
			cfg_loaded_o <= 1'b1;
		end
		else if (reg_wr_i)
		begin
			for (i = 0; i < NPIN; i = i + 1)
				if (reg_addr_i == `GCSC_ADDR_PIN_CFG0 + i[7:0])
					pin_cfg[i] <= reg_wdata_i;
			case (reg_addr_i)
			`GCSC_ADDR_POLARITY:
			begin
				if (i2c_mode_i)
					pol <= {pol[5:4], reg_wdata_i[3:0]};
				else
					pol <= reg_wdata_i[5:0];
			end
			`GCSC_ADDR_SYNC_MODE:
				sync_cfg <= reg_wdata_i;
			`GCSC_ADDR_RAIL_CTRL:
				host_rail <= reg_wdata_i[4:0];
			`GCSC_ADDR_OUT_VALUE:
				out_value <= reg_wdata_i[5:0];
			default:
				host_rail <= host_rail;
			endcase
		end
	end

	// internal oscillator stand-in; its rate follows the user setting
	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			int_cnt <= 4'h0;
			int_lvl <= 1'b0;
			ext_d <= 1'b0;
		end
		else
		begin
			ext_d <= ext_lvl;
			if (int_cnt >= half - 4'h1)
			begin
				int_cnt <= 4'h0;
				int_lvl <= !int_lvl;
			end
			else
				int_cnt <= int_cnt + 4'h1;
		end
	end

	// lowest-numbered pin set as clock input supplies the external clock
	always @*
	begin
		clk_idx = 3'h0;
		clk_found = 1'b0;
		for (i = NPIN - 1; i >= 0; i = i - 1)
			if (cfg_func(pin_cfg[i]) == `GCSC_FUNC_CLK_IN)
			begin
				clk_idx = i[2:0];
				clk_found = 1'b1;
			end
	end

	gcsc_freq_det #(
		.WIN(DET_WINDOW),
		.CW(8)
	) u_det (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.clear_i(!clk_found),
		.ref_rise_i(int_rise),
		.ext_rise_i(ext_rise),
		.pct_i(sync_cfg[`GCSC_SYNC_PCT_MSB:`GCSC_SYNC_PCT_LSB]),
		.lock_o(lock),
		.win_done_o(win_done)
	);

	// external clock request: only after the load and a good window
	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			ext_latch <= 1'b0;
		else if (!cfg_loaded_o || !ext_mode || !clk_found)
			ext_latch <= 1'b0;
		else if (win_done && lock)
			ext_latch <= 1'b1;
		else if (win_done && !lock && sync_cfg[`GCSC_SYNC_AUTOBACK])
			ext_latch <= 1'b0;
	end

	gcsc_clk_mux u_mux (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.int_lvl_i(int_lvl),
		.ext_lvl_i(ext_lvl),
		.want_ext_i(ext_latch),
		.main_clk_o(main_clk_o),
		.ext_active_o(ext_clk_active_o)
	);

	// sync marker: high for one main clock period every SYNC_DIV periods
	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			main_d <= 1'b0;
			sync_cnt <= 8'h00;
			sync_lvl <= 1'b0;
		end
		else
		begin
			main_d <= main_clk_o;
			if (main_rise)
			begin
				sync_lvl <= (sync_cnt == 8'h00);
				if (sync_cnt >= sync_last)
					sync_cnt <= 8'h00;
				else
					sync_cnt <= sync_cnt + 8'h01;
			end
		end
	end

	// per-pin drive and rail requests
	always @*
	begin
		next_out = 6'h00;
		next_oe = 6'h00;
		pin_rail_req = 5'h00;
		for (i = 0; i < NPIN; i = i + 1)
		begin
			case (cfg_func(pin_cfg[i]))
			`GCSC_FUNC_OUTPUT:
			begin
				next_out[i] = out_value[i];
				next_oe[i] = 1'b1;
			end
			`GCSC_FUNC_CLK_OUT:
			begin
				next_out[i] = mst_on && main_clk_o;
				next_oe[i] = mst_on;
			end
			`GCSC_FUNC_SYNC_OUT:
			begin
				next_out[i] = mst_on && sync_lvl;
				next_oe[i] = mst_on;
			end
			`GCSC_FUNC_RAIL_EN:
			begin
				// selector is a rail mask: bucks in bits 3:0, standby in bit 4
				if (eff_in[i])
					pin_rail_req = pin_rail_req | cfg_sel(pin_cfg[i]);
			end
			`GCSC_FUNC_PWR_GOOD:
			begin
				next_out[i] = (cfg_sel(pin_cfg[i]) != 5'h00)
					&& ((rail_pg_i & cfg_sel(pin_cfg[i])) == cfg_sel(pin_cfg[i]));
				next_oe[i] = 1'b1;
			end
			`GCSC_FUNC_EVENT:
			begin
				// codes past the last event drive inactive
				if (cfg_sel(pin_cfg[i]) < `GCSC_NUM_EVENTS)
					next_out[i] = event_i[cfg_sel(pin_cfg[i])];
				next_oe[i] = 1'b1;
			end
			default:
				next_oe[i] = 1'b0;
			endcase
		end
		next_out = next_out ^ pol;
	end

	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			gpio_out_o <= 6'h00;
			gpio_oe_o <= 6'h00;
			rail_en_o <= 5'h00;
		end
		else
		begin
			gpio_out_o <= next_out;
			gpio_oe_o <= next_oe;
			// host and pin requests are ORed so either one can hold a rail on
			rail_en_o <= host_rail | pin_rail_req;
		end
	end

	// read-back; unmapped addresses return zero
	always @*
	begin
		next_rdata = 16'h0000;
		for (i = 0; i < NPIN; i = i + 1)
			if (reg_addr_i == `GCSC_ADDR_PIN_CFG0 + i[7:0])
				next_rdata = pin_cfg[i];
		case (reg_addr_i)
		`GCSC_ADDR_POLARITY:
			next_rdata = {10'h000, pol};
		`GCSC_ADDR_SYNC_MODE:
			next_rdata = sync_cfg;
		`GCSC_ADDR_RAIL_CTRL:
			next_rdata = {11'h000, host_rail};
		`GCSC_ADDR_OUT_VALUE:
			next_rdata = {10'h000, out_value};
		`GCSC_ADDR_PG_SS:
			next_rdata = {3'h0, rail_ss_done_i, 3'h0, rail_pg_i};
		`GCSC_ADDR_CLK_STATUS:
			next_rdata = {9'h000, clk_idx, clk_found, cfg_loaded_o, lock, ext_clk_active_o};
		`GCSC_ADDR_PIN_STATUS:
			next_rdata = {10'h000, eff_in};
		`GCSC_ADDR_TARGET_ADDR:
			next_rdata = {9'h000, target_addr_o};
		default:
			next_rdata = next_rdata;
		endcase
	end

	always @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			reg_rdata_o <= 16'h0000;
			reg_rvalid_o <= 1'b0;
		end
		else
		begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
				reg_rdata_o <= next_rdata;
		end
	end
endmodule // gcsc_top

/* File: dv/gcsc_props.sv */
// assertion checker for the pin function and clock sync top
`timescale 1ns/1ps
`include "gcsc_consts.vh"
module gcsc_props (
	input wire core_clk_i,
	input wire rst_b_i,
	input wire reg_rd_i,
	input wire [7:0] reg_addr_i,
	input wire [15:0] reg_rdata_o,
	input wire reg_rvalid_o,
	input wire otp_load_i,
	input wire [6:0] otp_taddr_i,
	input wire [4:0] rail_pg_i,
	input wire [4:0] rail_ss_done_i,
	input wire main_clk_o,
	input wire ext_clk_active_o,
	input wire cfg_loaded_o,
	input wire [6:0] target_addr_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
	rd_quiet_a: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray read valid");
	pg_status_a: assert property (reg_rd_i && reg_addr_i == `GCSC_ADDR_PG_SS |=>
		reg_rdata_o == {3'h0, $past(rail_ss_done_i), 3'h0, $past(rail_pg_i)}) else $error("bad pg status");
	int_start_a: assert property ($rose(rst_b_i) |-> !ext_clk_active_o) else $error("not internal at start");
	ext_after_load_a: assert property (!cfg_loaded_o |-> !ext_clk_active_o) else $error("ext before load");
	load_addr_a: assert property (otp_load_i |=> cfg_loaded_o && target_addr_o == $past(otp_taddr_i))
		else $error("otp load not applied");
	load_sticky_a: assert property (cfg_loaded_o |=> cfg_loaded_o) else $error("loaded flag dropped");
	switch_edge_a: assert property ($changed(ext_clk_active_o) |-> $rose(main_clk_o))
		else $error("switch off edge");
	high_phase_a: assert property ($rose(main_clk_o) |=> main_clk_o) else $error("short high phase");
endmodule // gcsc_props
bind gcsc_top gcsc_props u_props (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_rd_i(reg_rd_i),
	.reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .otp_load_i(otp_load_i),
	.otp_taddr_i(otp_taddr_i), .rail_pg_i(rail_pg_i), .rail_ss_done_i(rail_ss_done_i), .main_clk_o(main_clk_o),
	.ext_clk_active_o(ext_clk_active_o), .cfg_loaded_o(cfg_loaded_o), .target_addr_o(target_addr_o));

/* File: dv/gcsc_ext_src.sv */
// behavioural external clock source at a clock-input pin
`timescale 1ns/1ps
module gcsc_ext_src (
	input wire run_i,
	input wire [7:0] half_ns_i,
	output reg clk_o
);
	initial clk_o = 1'b0;
	// idle low between bursts, offset 1ns off the core edges
	always
	begin
		if (run_i)
			#(half_ns_i) clk_o = ~clk_o;
		else
		begin
			clk_o = 1'b0;
			@(run_i);
			#1;
		end
	end
endmodule // gcsc_ext_src

/* File: dv/testbench.sv */
// self-checking bench for the pin function and clock sync top
`timescale 1ns/1ps
module testbench;
	reg clk = 1'b0;
	reg rst_b = 1'b0;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [15:0] wdata = 16'h0000;
	reg i2c = 1'b0;
	reg load = 1'b0;
	reg [5:0] pins = 6'h00;
	reg [4:0] pg = 5'h00;
	reg [4:0] ss = 5'h00;
	reg [17:0] ev = 18'h00000;
	reg run = 1'b0;
	reg [7:0] half = 8'h10;
	wire ext;
	wire [15:0] rdata;
	wire [5:0] gout;
	wire [5:0] goe;
	wire [4:0] rails;
	wire act;
	wire loaded;
	wire [6:0] taddr;
	integer mismatches = 0;
	integer samples_checked = 0;
	integer i;
	always #2 clk = ~clk;
	gcsc_ext_src u_src (.run_i(run), .half_ns_i(half), .clk_o(ext));
	gcsc_top u_dut (.core_clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(), .i2c_mode_i(i2c), .otp_load_i(load),
		.otp_pin_cfg_i({16'h0000, 16'h0200, 64'h0}), .otp_pol_i(6'h00), .otp_sync_i(16'h0053),
		.otp_taddr_i(7'h2a), .gpio_in_i({pins[5], ext, pins[3:0]}), .gpio_out_o(gout), .gpio_oe_o(goe),
		.rail_pg_i(pg), .rail_ss_done_i(ss), .event_i(ev), .rail_en_o(rails), .main_clk_o(),
		.ext_clk_active_o(act), .cfg_loaded_o(loaded), .target_addr_o(taddr));
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	task chk(input [15:0] g, input [15:0] e);
	begin
		samples_checked = samples_checked + 1;
		if (g !== e)
		begin
			mismatches = mismatches + 1;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	task cyc(input integer n);
	begin
		repeat (n) @(posedge clk);
		#1;
	end
	endtask
	task wreg(input [7:0] a, input [15:0] d);
	begin
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask
	task rreg(input [7:0] a, input [15:0] e);
	begin
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	end
	endtask
	task wait_act(input v);
	begin
		for (i = 0; i < 3000 && act !== v; i = i + 1)
			@(posedge clk);
		#1;
	end
	endtask
	task t_reset;
	begin
		chk(act, 1'b0);
		rreg(8'h07, 16'h0050);
		rreg(8'h06, 16'h0000);
		$display("reset done");
	end
	endtask
	task t_otp;
	begin
		@(posedge clk);
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		#1;
		chk(taddr, 7'h2a);
		rreg(8'h04, 16'h0200);
		rreg(8'h0d, 16'h002a);
		rreg(8'h07, 16'h0053);
		$display("otp done");
	end
	endtask
	task t_pol;
	begin
		@(posedge clk);
		i2c <= 1'b1;
		wreg(8'h06, 16'h003f);
		rreg(8'h06, 16'h000f);
		@(posedge clk);
		i2c <= 1'b0;
		wreg(8'h06, 16'h003f);
		rreg(8'h06, 16'h003f);
		rreg(8'h0c, 16'h003f);
		wreg(8'h00, 16'h0100);
		wreg(8'h09, 16'h0001);
		cyc(3);
		chk(gout[0], 1'b0);
		wreg(8'h06, 16'h0000);
		cyc(3);
		chk(gout[0], 1'b1);
		$display("polarity done");
	end
	endtask
	task t_rail;
	begin
		wreg(8'h01, 16'h0511);
		@(posedge clk);
		pins[1] <= 1'b1;
		cyc(5);
		chk(rails, 5'h11);
		@(posedge clk);
		pins[1] <= 1'b0;
		cyc(5);
		chk(rails, 5'h00);
		wreg(8'h08, 16'h0010);
		cyc(3);
		chk(rails, 5'h10);
		$display("rail done");
	end
	endtask
	task t_pg;
	begin
		wreg(8'h02, 16'h0603);
		@(posedge clk);
		pg <= 5'h03;
		ss <= 5'h1f;
		cyc(4);
		chk({goe[2], gout[2]}, 2'h3);
		rreg(8'h0a, 16'h1f03);
		@(posedge clk);
		pg <= 5'h01;
		cyc(4);
		chk(gout[2], 1'b0);
		$display("power good done");
	end
	endtask
	task t_event;
		integer c;
	begin
		for (c = 0; c < 19; c = c + 1)
		begin
			wreg(8'h03, 16'h0700 | c);
			@(posedge clk);
			ev <= 18'h3ffff ^ (18'h1 << c);
			cyc(4);
			chk(gout[3], 1'b0);
			@(posedge clk);
			ev <= 18'h1 << c;
			cyc(4);
			chk(gout[3], c < 18);
		end
		$display("event done");
	end
	endtask
	task t_master;
	begin
		wreg(8'h05, 16'h0300);
		wreg(8'h07, 16'h0054);
		cyc(3);
		chk(goe[5], 1'b1);
		rreg(8'h07, 16'h0054);
		wreg(8'h07, 16'h0050);
		cyc(3);
		chk(goe[5], 1'b0);
		$display("master done");
	end
	endtask
	task t_sync;
	begin
		wreg(8'h07, 16'h0053);
		@(posedge clk);
		run <= 1'b1;
		wait_act(1'b1);
		chk(act, 1'b1);
		@(posedge clk);
		run <= 1'b0;
		wait_act(1'b0);
		chk(act, 1'b0);
		@(posedge clk);
		half <= 8'h18;
		run <= 1'b1;
		cyc(2000);
		chk(act, 1'b0);
		@(posedge clk);
		run <= 1'b0;
		half <= 8'h10;
		wreg(8'h07, 16'h005a);
		@(posedge clk);
		run <= 1'b1;
		wait_act(1'b1);
		chk(act, 1'b1);
		$display("sync done");
	end
	endtask
	initial
	begin
		#200000;
		mismatches = mismatches + 1;
		tally_and_finish;
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_reset;
		t_otp;
		t_pol;
		t_rail;
		t_pg;
		t_event;
		t_master;
		t_sync;
		tally_and_finish;
	end
endmodule // testbench
